// File: core/fdpc_config.sv
// Operation
// - Power-off bit at 1 stops the converter, at 0 runs it; resets to 0.
// - While powered down the bus stays usable and all registers are kept.
// - Delay field, bits 7:5 of the filter register, sets the start wait.
// - The delay counts modulator clocks, which run at half the device clock.
// - Delay codes 0..7 give 0,4,8,16,32,128,512,1024 mod clocks; reset 0.
// - Filter field in bits 4:0 selects filter type and oversampling ratio.
// - Codes 00000..00111 give wideband at ratios 32 up to 4096, doubling.
// - Codes 01000..01100 give sinc4 at ratios 12, 16, 24, 32, 64.
// - Filter register at index 7 resets to zero: no delay, wideband 32.
// - Codes 01101..10010 give sinc4 at ratios 128 up to 4096, doubling.
// - 10011..11011 give sinc4 32, then sinc1 2,4,10,20,40,100,200,400,1000.
// - 11100..11111 give sinc3 26667, sinc3 32000, sinc3 32000 + sinc1 3 or 5.
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module fdpc_config (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 resetn,
    // Avalon-MM slave, byte addresses
    input  wire logic [7:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    // Conversion start pin, asynchronous
    input  wire logic                 start_pin,
    // Converter control
    output logic                      converter_power_on,
    output logic                      start_delay_busy,
    output logic                      conversion_active,
    output fdpc_pkg::fdpc_filt_t      active_filter
);

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Delay in modulator clocks for a delay code
    function automatic logic [10:0] delay_cycles(input logic [2:0] code);
        case (code)
            3'h0:    delay_cycles = 11'h000;
            3'h1:    delay_cycles = 11'h004;
            3'h2:    delay_cycles = 11'h008;
            3'h3:    delay_cycles = 11'h010;
            3'h4:    delay_cycles = 11'h020;
            3'h5:    delay_cycles = 11'h080;
            3'h6:    delay_cycles = 11'h200;
            default: delay_cycles = 11'h400;
        endcase
    endfunction : delay_cycles

    // Filter type and ratios for a filter code
    function automatic fdpc_pkg::fdpc_filt_t filt_decode(
        input logic [4:0] code);
        fdpc_pkg::fdpc_filt_t f;
        f.ftype    = fdpc_pkg::FDPC_SINC4_SINC1;
        f.osr      = 16'h0020;
        f.post_osr = 10'h000;
        case (code)
            // Low sinc4 ratios follow no power of two
            5'h08:   begin f.ftype = fdpc_pkg::FDPC_SINC4; f.osr = 16'h000c; end
            5'h09:   begin f.ftype = fdpc_pkg::FDPC_SINC4; f.osr = 16'h0010; end
            5'h0a:   begin f.ftype = fdpc_pkg::FDPC_SINC4; f.osr = 16'h0018; end
            5'h0b:   begin f.ftype = fdpc_pkg::FDPC_SINC4; f.osr = 16'h0020; end
            5'h0c:   begin f.ftype = fdpc_pkg::FDPC_SINC4; f.osr = 16'h0040; end
            5'h13:   f.post_osr = 10'h002;
            5'h14:   f.post_osr = 10'h004;
            5'h15:   f.post_osr = 10'h00a;
            5'h16:   f.post_osr = 10'h014;
            5'h17:   f.post_osr = 10'h028;
            5'h18:   f.post_osr = 10'h064;
            5'h19:   f.post_osr = 10'h0c8;
            5'h1a:   f.post_osr = 10'h190;
            5'h1b:   f.post_osr = 10'h3e8;
            5'h1c:   begin f.ftype = fdpc_pkg::FDPC_SINC3; f.osr = 16'h682b; end
            5'h1d:   begin f.ftype = fdpc_pkg::FDPC_SINC3; f.osr = 16'h7d00; end
            5'h1e:   begin
                f.ftype    = fdpc_pkg::FDPC_SINC3_SINC1;
                f.osr      = 16'h7d00;
                f.post_osr = 10'h003;
            end
            5'h1f:   begin
                f.ftype    = fdpc_pkg::FDPC_SINC3_SINC1;
                f.osr      = 16'h7d00;
                f.post_osr = 10'h005;
            end
            default: begin
                if (code < 5'h08) begin
                    f.ftype = fdpc_pkg::FDPC_WIDEBAND;
                    f.osr   = 16'h0020 << code[2:0];
                end else begin
                    f.ftype = fdpc_pkg::FDPC_SINC4;
                    f.osr   = 16'h0080 << 4'(code - 5'h0d);
                end
            end
        endcase
        return f;
    endfunction : filt_decode

    // Byte address of a register index
    function automatic logic [7:0] reg_addr(input logic [7:0] idx);
        return 8'(idx << 2);
    endfunction : reg_addr

    // ****************************************************************
    // Modulator clock enable
    // ****************************************************************
    logic mod_tick;

    fdpc_mod_tick #(
        .DIV (fdpc_pkg::MOD_DIV)
    ) u_mod_tick (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .tick    (mod_tick)
    );

    // ****************************************************************
    // Register bus
    // ****************************************************************
    logic        ack_reg;
    logic        ack_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [7:0]  pwr_cfg_reg;
    logic [7:0]  pwr_cfg_next;
    logic [7:0]  filt_cfg_reg;
    logic [7:0]  filt_cfg_next;
    logic [4:0]  lat_code_reg;
    fdpc_pkg::fdpc_state_t state_reg;
    logic        wr_take;
    logic        pwr_off;

    assign wr_take = ack_reg && avs_write && avs_byteenable[0];
    assign pwr_off = pwr_cfg_reg[fdpc_pkg::PWR_OFF_BIT];

    // One wait cycle, then the answer; writes land at the ack edge
    always_comb begin
        ack_next      = (avs_read || avs_write) && !ack_reg;
        rdata_next    = rdata_reg;
        pwr_cfg_next  = pwr_cfg_reg;
        filt_cfg_next = filt_cfg_reg;
        if (ack_next && avs_read) begin
            rdata_next = 32'h0000_0000; // Unmapped reads as zero
            case (avs_address)
                reg_addr(fdpc_pkg::PWR_CFG_IDX):
                    rdata_next[7:0] = pwr_cfg_reg;
                reg_addr(fdpc_pkg::FILT_CFG_IDX):
                    rdata_next[7:0] = filt_cfg_reg;
                reg_addr(fdpc_pkg::STATUS_IDX): begin
                    rdata_next[fdpc_pkg::ST_WAIT_BIT] =
                        (state_reg == fdpc_pkg::FDPC_WAIT);
                    rdata_next[fdpc_pkg::ST_RUN_BIT]  =
                        (state_reg == fdpc_pkg::FDPC_RUN);
                    rdata_next[fdpc_pkg::ST_PWR_BIT]  = pwr_off;
                    rdata_next[7:fdpc_pkg::ST_CODE_LSB] = lat_code_reg;
                end
                default: rdata_next = 32'h0000_0000;
            endcase
        end
        // Bus stays live regardless of power-off
        if (wr_take && avs_address == reg_addr(fdpc_pkg::PWR_CFG_IDX))
            pwr_cfg_next = {7'h00, avs_writedata[fdpc_pkg::PWR_OFF_BIT]};
        if (wr_take && avs_address == reg_addr(fdpc_pkg::FILT_CFG_IDX))
            filt_cfg_next = avs_writedata[7:0];
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ack_reg      <= 1'b0;
            rdata_reg    <= 32'h0000_0000;
            pwr_cfg_reg  <= fdpc_pkg::PWR_CFG_RST;
            filt_cfg_reg <= fdpc_pkg::FILT_CFG_RST;
        end else begin
            ack_reg      <= ack_next;
            rdata_reg    <= rdata_next;
            pwr_cfg_reg  <= pwr_cfg_next;
            filt_cfg_reg <= filt_cfg_next;
        end
    end

    assign avs_readdata    = rdata_reg;
    assign avs_waitrequest = !ack_reg;

    // ****************************************************************
    // Start pin synchroniser
    // ****************************************************************
    logic start_s1_reg;
    logic start_s2_reg;
    logic start_s3_reg;
    logic start_lvl_reg;
    logic start_lvl_next;
    logic start_rise;

    // Accept a new level only when the last two stages agree
    always_comb begin
        start_lvl_next = start_lvl_reg;
        if (start_s2_reg == start_s3_reg)
            start_lvl_next = start_s3_reg;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            start_s1_reg  <= 1'b0;
            start_s2_reg  <= 1'b0;
            start_s3_reg  <= 1'b0;
            start_lvl_reg <= 1'b0;
        end else begin
            start_s1_reg  <= start_pin;
            start_s2_reg  <= start_s1_reg;
            start_s3_reg  <= start_s2_reg;
            start_lvl_reg <= start_lvl_next;
        end
    end

    assign start_rise = start_lvl_next && !start_lvl_reg;

    // ****************************************************************
    // Start sequencer
    // ****************************************************************
    fdpc_pkg::fdpc_state_t state_next;
    logic [10:0]           dly_cnt_reg;
    logic [10:0]           dly_cnt_next;
    logic [4:0]            lat_code_next;
    fdpc_pkg::fdpc_filt_t  filt_reg;
    fdpc_pkg::fdpc_filt_t  filt_next;
    logic                  power_on_reg;
    logic [2:0]            dly_code;

    assign dly_code = filt_cfg_reg[fdpc_pkg::DELAY_MSB:fdpc_pkg::DELAY_LSB];

    // Settings are sampled only at a start, so edits cannot disturb
    // a conversion already under way
    always_comb begin
        state_next    = state_reg;
        dly_cnt_next  = dly_cnt_reg;
        lat_code_next = lat_code_reg;
        filt_next     = filt_reg;
        case (state_reg)
            fdpc_pkg::FDPC_IDLE: begin
                if (start_rise && !pwr_off) begin
                    lat_code_next = filt_cfg_reg[4:0];
                    filt_next     = filt_decode(filt_cfg_reg[4:0]);
                    dly_cnt_next  = delay_cycles(dly_code);
                    state_next    = (dly_code == 3'h0) ?
                                    fdpc_pkg::FDPC_RUN : fdpc_pkg::FDPC_WAIT;
                end
            end
            fdpc_pkg::FDPC_WAIT: begin
                if (dly_cnt_reg == 11'h000)
                    state_next = fdpc_pkg::FDPC_RUN;
                else if (mod_tick)
                    dly_cnt_next = dly_cnt_reg - 11'h001;
            end
            fdpc_pkg::FDPC_RUN: begin
                if (!start_lvl_reg)
                    state_next = fdpc_pkg::FDPC_IDLE;
            end
            default: state_next = fdpc_pkg::FDPC_IDLE;
        endcase
        // Power-off aborts any sequence; register bank untouched
        if (pwr_off)
            state_next = fdpc_pkg::FDPC_IDLE;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg    <= fdpc_pkg::FDPC_IDLE;
            dly_cnt_reg  <= 11'h000;
            lat_code_reg <= 5'h00;
            filt_reg     <= '{fdpc_pkg::FDPC_WIDEBAND, 16'h0020, 10'h000};
            power_on_reg <= 1'b1;
        end else begin
            state_reg    <= state_next;
            dly_cnt_reg  <= dly_cnt_next;
            lat_code_reg <= lat_code_next;
            filt_reg     <= filt_next;
            power_on_reg <= !pwr_cfg_next[fdpc_pkg::PWR_OFF_BIT];
        end
    end

    assign converter_power_on = power_on_reg;
    assign start_delay_busy   = (state_reg == fdpc_pkg::FDPC_WAIT);
    assign conversion_active  = (state_reg == fdpc_pkg::FDPC_RUN);
    assign active_filter      = filt_reg;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_pwr_stop;
        @(posedge ref_clk) disable iff (!resetn)
        pwr_off |=> (state_reg == fdpc_pkg::FDPC_IDLE)
            && (power_on_reg == !pwr_off);
    endproperty
    a_pwr_stop: assert property (p_pwr_stop)
        else $error("power-off did not stop the converter");

    property p_retain;
        @(posedge ref_clk) disable iff (!resetn)
        pwr_off && !wr_take |=> $stable(filt_cfg_reg);
    endproperty
    a_retain: assert property (p_retain)
        else $error("settings lost while powered down");

    property p_dly_load;
        @(posedge ref_clk) disable iff (!resetn)
        (state_reg == fdpc_pkg::FDPC_IDLE) && start_rise && !pwr_off
            && dly_code != 3'h0
        |=> (state_reg == fdpc_pkg::FDPC_WAIT)
            && dly_cnt_reg == delay_cycles($past(dly_code));
    endproperty
    a_dly_load: assert property (p_dly_load)
        else $error("start delay not loaded from delay field");

    property p_mod_count;
        @(posedge ref_clk) disable iff (!resetn)
        (state_reg == fdpc_pkg::FDPC_WAIT) && !mod_tick && !pwr_off
        |=> $stable(dly_cnt_reg);
    endproperty
    a_mod_count: assert property (p_mod_count)
        else $error("delay counted off modulator clock");

    property p_zero_dly;
        @(posedge ref_clk) disable iff (!resetn)
        (state_reg == fdpc_pkg::FDPC_IDLE) && start_rise && !pwr_off
            && dly_code == 3'h0
        |=> conversion_active;
    endproperty
    a_zero_dly: assert property (p_zero_dly)
        else $error("zero delay did not start at once");

    property p_decode;
        @(posedge ref_clk) disable iff (!resetn)
        $rose(state_reg != fdpc_pkg::FDPC_IDLE)
        |-> filt_reg == filt_decode(lat_code_reg);
    endproperty
    a_decode: assert property (p_decode)
        else $error("active filter does not match its code");

    property p_wr_cfg;
        @(posedge ref_clk) disable iff (!resetn)
        wr_take && avs_address == reg_addr(fdpc_pkg::FILT_CFG_IDX)
        |=> filt_cfg_reg == $past(avs_writedata[7:0]) && avs_waitrequest;
    endproperty
    a_wr_cfg: assert property (p_wr_cfg)
        else $error("filter register write misplaced");

    property p_hold;
        @(posedge ref_clk) disable iff (!resetn)
        (state_reg != fdpc_pkg::FDPC_IDLE)
        |=> (state_reg == fdpc_pkg::FDPC_IDLE)
            || ($stable(filt_reg) && $stable(lat_code_reg));
    endproperty
    a_hold: assert property (p_hold)
        else $error("settings changed during a conversion");

endmodule : fdpc_config
`default_nettype wire

// File: core/fdpc_pkg.sv
`default_nettype none
package fdpc_pkg;

    // ****************************************************************
    // Register map (word index, byte address is four times the index)
    // ****************************************************************
    localparam logic [7:0] PWR_CFG_IDX    = 8'h06;
    localparam logic [7:0] FILT_CFG_IDX   = 8'h07;
    localparam logic [7:0] STATUS_IDX     = 8'h20;
    localparam logic [7:0] PWR_CFG_RST    = 8'h00;
    localparam logic [7:0] FILT_CFG_RST   = 8'h00;

    // Field positions
    localparam int PWR_OFF_BIT   = 0;
    localparam int DELAY_MSB     = 7;
    localparam int DELAY_LSB     = 5;
    localparam int FILT_MSB      = 4;
    localparam int FILT_LSB      = 0;
    localparam int ST_WAIT_BIT   = 0;
    localparam int ST_RUN_BIT    = 1;
    localparam int ST_PWR_BIT    = 2;
    localparam int ST_CODE_LSB   = 3;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int REF_CLK_MHZ   = 100;
    localparam int MOD_DIV       = 2;
    localparam int DLY_W         = 11;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        FDPC_WIDEBAND    = 3'h0,
        FDPC_SINC4       = 3'h1,
        FDPC_SINC4_SINC1 = 3'h2,
        FDPC_SINC3       = 3'h3,
        FDPC_SINC3_SINC1 = 3'h4
    } fdpc_ftype_t;

    typedef struct packed {
        fdpc_ftype_t ftype;
        logic [15:0] osr;
        logic [9:0]  post_osr;
    } fdpc_filt_t;

    typedef enum logic [1:0] {
        FDPC_IDLE = 2'h0,
        FDPC_WAIT = 2'h1,
        FDPC_RUN  = 2'h2
    } fdpc_state_t;

endpackage : fdpc_pkg
`default_nettype wire

// File: core/fdpc_mod_tick.sv
`timescale 1ns/100ps
`default_nettype none
module fdpc_mod_tick #(
    parameter int DIV = fdpc_pkg::MOD_DIV
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic resetn,
    // Modulator clock enable
    output logic      tick
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          tick_reg;
    logic          tick_next;

    // Wrap the divider; one pulse per modulator clock period
    always_comb begin
        tick_next = (cnt_reg == CW'(DIV - 1));
        cnt_next  = tick_next ? '0 : cnt_reg + CW'(1);
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;

endmodule : fdpc_mod_tick
`default_nettype wire

// File: sim/fdpc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module fdpc_host_model (
    // Clock
    input  wire logic        ref_clk,
    // Avalon-MM master side
    output logic      [7:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    output logic      [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest,
    // Conversion start level
    output logic             start_pin
);

    // ****************************************************************
    // Idle levels
    // ****************************************************************
    initial begin
        avs_address    = 8'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h00000000;
        avs_byteenable = 4'h0;
        start_pin      = 1'b0;
    end

    // One bus cycle, held until waitrequest is seen low at an edge
    task automatic bus_xfer(input logic wr, input logic [7:0] addr,
                            input logic [31:0] wdata, input logic [3:0] be,
                            output logic [31:0] rdata);
        @(posedge ref_clk);
        avs_address    <= addr;
        avs_writedata  <= wdata;
        avs_byteenable <= be;
        avs_write      <= wr;
        avs_read       <= !wr;
        // No local limit: a hung slave is left to the bench watchdog
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        // Released lines flip so a stale address is never mistaken for live
        avs_address    <= ~addr;
        avs_writedata  <= ~wdata;
        avs_byteenable <= ~be;
    endtask : bus_xfer

    // Start level changes only just after an edge
    task automatic set_start(input logic lvl);
        @(posedge ref_clk);
        start_pin <= lvl;
    endtask : set_start

endmodule : fdpc_host_model
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;

    // ****************************************************************
    // Nets and counters
    // ****************************************************************
    localparam logic [7:0] A_PWR  = fdpc_pkg::PWR_CFG_IDX << 2;
    localparam logic [7:0] A_FILT = fdpc_pkg::FILT_CFG_IDX << 2;
    localparam logic [7:0] A_STAT = fdpc_pkg::STATUS_IDX << 2;
    logic                 ref_clk;
    logic                 resetn;
    logic [7:0]           avs_address;
    logic                 avs_read;
    logic                 avs_write;
    logic [31:0]          avs_writedata;
    logic [3:0]           avs_byteenable;
    logic [31:0]          avs_readdata;
    logic                 avs_waitrequest;
    logic                 start_pin;
    logic                 converter_power_on;
    logic                 start_delay_busy;
    logic                 conversion_active;
    fdpc_pkg::fdpc_filt_t active_filter;
    int                   errors;
    int                   n_compared;
    int                   dly [8] = '{32'h0, 32'h4, 32'h8, 32'h10,
                                      32'h20, 32'h80, 32'h200, 32'h400};

    fdpc_config fdpc_config_i (
        .ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .start_pin(start_pin), .converter_power_on(converter_power_on),
        .start_delay_busy(start_delay_busy),
        .conversion_active(conversion_active),
        .active_filter(active_filter));

    fdpc_host_model fdpc_host_model_i (
        .ref_clk(ref_clk), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .start_pin(start_pin));

    // 100 MHz clock
    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    // Filter selection expected for each code
    function automatic fdpc_pkg::fdpc_filt_t exp_filt(input logic [4:0] c);
        fdpc_pkg::fdpc_filt_t f;
        logic [15:0] lo [5] = '{16'h000c, 16'h0010, 16'h0018, 16'h0020,
                                16'h0040};
        logic [9:0] s1 [9] = '{10'h002, 10'h004, 10'h00a, 10'h014, 10'h028,
                               10'h064, 10'h0c8, 10'h190, 10'h3e8};
        f.post_osr = 10'h000;
        f.osr      = 16'h7d00;
        if (c < 5'h08) begin
            f.ftype = fdpc_pkg::FDPC_WIDEBAND;
            f.osr   = 16'h0020 << c;
        end else if (c < 5'h0d) begin
            f.ftype = fdpc_pkg::FDPC_SINC4;
            f.osr   = lo[c - 5'h08];
        end else if (c < 5'h13) begin
            f.ftype = fdpc_pkg::FDPC_SINC4;
            f.osr   = 16'h0080 << (c - 5'h0d);
        end else if (c < 5'h1c) begin
            f.ftype    = fdpc_pkg::FDPC_SINC4_SINC1;
            f.osr      = 16'h0020;
            f.post_osr = s1[c - 5'h13];
        end else if (c < 5'h1e) begin
            f.ftype = fdpc_pkg::FDPC_SINC3;
            f.osr   = (c == 5'h1c) ? 16'h682b : 16'h7d00;
        end else begin
            f.ftype    = fdpc_pkg::FDPC_SINC3_SINC1;
            f.post_osr = (c == 5'h1e) ? 10'h003 : 10'h005;
        end
        return f;
    endfunction : exp_filt

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        fdpc_host_model_i.bus_xfer(1'b1, a, {24'h000000, d}, 4'hf, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        fdpc_host_model_i.bus_xfer(1'b0, a, 32'h00000000, 4'hf, r);
        check(r, exp);
    endtask : rd

    // Waits a bounded time for the conversion flag to reach a level
    task automatic wait_act(input logic lvl, input int lim, output int n,
                            output logic busy_seen);
        n         = 0;
        busy_seen = 1'b0;
        do begin
            @(posedge ref_clk);
            n++;
            if (start_delay_busy === 1'b1) busy_seen = 1'b1;
        end while (conversion_active !== lvl && n < lim);
    endtask : wait_act

    task automatic start_run(input logic [7:0] cfg, output int n,
                             output logic b);
        wr(A_FILT, cfg);
        fdpc_host_model_i.set_start(1'b1);
        wait_act(1'b1, 3000, n, b);
        check(conversion_active, 1'b1);
    endtask : start_run

    // Drop the level and let the synchroniser settle before the next rise
    task automatic stop_run;
        int   n;
        logic b;
        fdpc_host_model_i.set_start(1'b0);
        wait_act(1'b0, 40, n, b);
        repeat (2) @(posedge ref_clk);
    endtask : stop_run

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        int   n;
        logic b;
        errors     = 0;
        n_compared = 0;
        resetn     = 1'b0;
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        rd(A_FILT, 32'h00000000);
        rd(A_PWR, 32'h00000000);
        check(converter_power_on, 1'b1);
        check(active_filter, exp_filt(5'h00));
        wr(8'h44, 8'hff);
        rd(8'h44, 32'h00000000);
        rd(A_FILT, 32'h00000000);
        $display("test reset_and_map done");
        // Every filter code, read back and applied at a start
        for (int c = 0; c < 32; c++) begin
            start_run({3'h0, 5'(c)}, n, b);
            check(active_filter, exp_filt(5'(c)));
            rd(A_FILT, {27'h0000000, 5'(c)});
            stop_run();
        end
        $display("test filter_codes done");
        // Every delay code, measured from the pin edge in ref clocks
        for (int d = 0; d < 8; d++) begin
            start_run({3'(d), 5'h01}, n, b);
            check(n >= 2 * dly[d] + 2, 1'b1);
            check(n <= 2 * dly[d] + 9, 1'b1);
            check(b, d > 0);
            rd(A_FILT, {24'h000000, 3'(d), 5'h01});
            stop_run();
        end
        $display("test start_delay done");
        // A write during a conversion only counts from the next start
        start_run(8'h0a, n, b);
        wr(A_FILT, 8'h1f);
        repeat (3) @(posedge ref_clk);
        check(active_filter, exp_filt(5'h0a));
        rd(A_STAT, 32'h00000052);
        stop_run();
        fdpc_host_model_i.set_start(1'b1);
        wait_act(1'b1, 3000, n, b);
        check(active_filter, exp_filt(5'h1f));
        $display("test latch_at_start done");
        // Power off in mid conversion, bus use while down, then resume
        wr(A_PWR, 8'h01);
        repeat (2) @(posedge ref_clk);
        check(converter_power_on, 1'b0);
        check(conversion_active, 1'b0);
        rd(A_STAT, {27'h0000000, 5'h1f} << 3 | 32'h4);
        stop_run();
        fdpc_host_model_i.set_start(1'b1);
        wait_act(1'b1, 40, n, b);
        check(conversion_active, 1'b0);
        rd(A_FILT, 32'h0000001f);
        rd(A_PWR, 32'h00000001);
        wr(A_FILT, 8'h45);
        rd(A_FILT, 32'h00000045);
        wr(A_PWR, 8'h00);
        wait_act(1'b1, 40, n, b);
        check(conversion_active, 1'b0);
        check(converter_power_on, 1'b1);
        stop_run();
        fdpc_host_model_i.set_start(1'b1);
        wait_act(1'b1, 3000, n, b);
        check(active_filter, exp_filt(5'h05));
        stop_run();
        $display("test power_off done");
        // A write with lane 0 disabled leaves the register alone
        fdpc_host_model_i.bus_xfer(1'b1, A_FILT, 32'h000000ff, 4'he, n);
        rd(A_FILT, 32'h00000045);
        $display("test byte_lane done");
        print_verdict();
    end

    // Watchdog far beyond the expected few thousand cycles
    initial begin
        repeat (30000) @(posedge ref_clk);
        errors++;
        $display("[ERR] %0t: watchdog expired", $time);
        print_verdict();
    end

endmodule : tb
`default_nettype wire
